// ---- rtl/pmsr_status_bank.sv ----
`timescale 1ns/1ps
`include "pmsr_params.svh"
module pmsr_status_bank
    import pmsr_pkg::*;
#(
    parameter int UV_FILTER_CYC = `PMSR_UV_FILTER_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Serial control interface
    input  wire logic        spi_csel_n,
    input  wire logic        spi_sclk,
    input  wire logic        serial_data_input,
    output logic             spi_miso,
    output logic             spi_miso_oe_n,
    // Detector events and conditions
    input  wire logic [15:0] first_event,
    input  wire logic [15:0] second_event,
    input  wire logic [15:0] third_event,
    input  wire logic        supply_uv_raw,
    input  wire logic        supply_ov_raw,
    input  wire logic        thermal_shutdown_second_level_event,
    input  wire logic        failsafe_event,
    input  wire logic        watchdog_trigger_ok,
    input  wire logic        lockout_enable_setting,
    // Status views
    output logic [15:0]      first_status_register,
    output logic [15:0]      second_status_register,
    output logic [15:0]      third_status_register,
    output logic [7:0]       global_status_ff
);

    pmsr_frame_e  state_ff;
    pmsr_frame_e  nxt_state;
    logic [4:0]   bit_cnt_ff;
    logic [4:0]   nxt_bit_cnt;
    logic [7:0]   cmd_ff;
    logic [7:0]   nxt_cmd;
    logic [7:0]   glob_snap_ff;
    logic [7:0]   nxt_glob_snap;
    logic [15:0]  data_snap_ff;
    logic [15:0]  nxt_data_snap;
    logic         miso_ff;
    logic         nxt_miso;
    logic         sclk_d_ff;
    logic         csel_d_ff;
    logic         sclk_rise;
    logic         sclk_fall;
    logic         frame_start;
    logic         frame_end;
    logic         frame_ok;
    logic         clr_first;
    logic         clr_second;
    logic         clr_third;
    logic         comm_err_evt;
    logic [23:0]  out_word;

    logic [12:0]  uv_cnt_ff;
    logic [12:0]  nxt_uv_cnt;
    logic         uv_filt;
    logic         comm_ff;
    logic         nxt_comm;
    logic         not_cold_ff;
    logic         nxt_not_cold;
    logic         thermal_shutdown_second_level_ff;
    logic         nxt_thermal_shutdown_second_level;
    logic         fsafe_ff;
    logic         nxt_fsafe;
    logic [7:0]   nxt_global;

    logic [15:0]  s1_event;
    logic [15:0]  s1_follow;
    logic [15:0]  s1_q;
    logic [15:0]  s2_q;
    logic [15:0]  s3_q;

    // Edge detection on inputs that are already synchronous to clk_sys.
    assign sclk_rise   = spi_sclk & ~sclk_d_ff & ~spi_csel_n;
    assign sclk_fall   = ~spi_sclk & sclk_d_ff & ~spi_csel_n;
    assign frame_start = ~spi_csel_n & csel_d_ff;
    assign frame_end   = spi_csel_n & ~csel_d_ff;
    assign frame_ok    = (bit_cnt_ff == `PMSR_FRAME_BITS);
    assign comm_err_evt = frame_end & ~frame_ok;
    assign clr_first   = frame_end & frame_ok & (cmd_ff[7:6] == `PMSR_OP_READ_CLEAR)
                         & (cmd_ff[5:0] == `PMSR_ADDR_FIRST);
    assign clr_second  = frame_end & frame_ok & (cmd_ff[7:6] == `PMSR_OP_READ_CLEAR)
                         & (cmd_ff[5:0] == `PMSR_ADDR_SECOND);
    assign clr_third   = frame_end & frame_ok & (cmd_ff[7:6] == `PMSR_OP_READ_CLEAR)
                         & (cmd_ff[5:0] == `PMSR_ADDR_THIRD);
    assign out_word    = {glob_snap_ff, data_snap_ff};

    // Frame shifter: the global byte goes out with the command, the register after it.
    always_comb begin
        nxt_state     = state_ff;
        nxt_bit_cnt   = bit_cnt_ff;
        nxt_cmd       = cmd_ff;
        nxt_glob_snap = glob_snap_ff;
        nxt_data_snap = data_snap_ff;
        nxt_miso      = miso_ff;
        unique case (state_ff)
            PMSR_IDLE: begin
                if (frame_start) begin
                    nxt_state     = PMSR_CMD;
                    nxt_bit_cnt   = 5'd0;
                    nxt_glob_snap = global_status_ff;
                    nxt_data_snap = 16'h0000;
                    nxt_miso      = global_status_ff[7];
                end
            end
            PMSR_CMD: begin
                if (frame_end) begin
                    nxt_state = PMSR_IDLE;
                end else if (sclk_rise) begin
                    nxt_cmd     = {cmd_ff[6:0], serial_data_input};
                    nxt_bit_cnt = bit_cnt_ff + 5'd1;
                    if (bit_cnt_ff == `PMSR_CMD_BITS - 5'd1) begin
                        nxt_state = PMSR_DATA;
                        unique case ({cmd_ff[4:0], serial_data_input})
                            `PMSR_ADDR_FIRST:  nxt_data_snap = first_status_register;
                            `PMSR_ADDR_SECOND: nxt_data_snap = second_status_register;
                            `PMSR_ADDR_THIRD:  nxt_data_snap = third_status_register;
                            default:           nxt_data_snap = 16'h0000;
                        endcase
                    end
                end else if (sclk_fall) begin
                    nxt_miso = out_word[5'd23 - bit_cnt_ff];
                end
            end
            PMSR_DATA: begin
                if (frame_end) begin
                    nxt_state = PMSR_IDLE;
                end else if (sclk_rise) begin
                    // Counting saturates so an overlong frame is still caught.
                    if (bit_cnt_ff != 5'd31) begin
                        nxt_bit_cnt = bit_cnt_ff + 5'd1;
                    end
                end else if (sclk_fall) begin
                    nxt_miso = (bit_cnt_ff < `PMSR_FRAME_BITS) ?
                               out_word[5'd23 - bit_cnt_ff] : 1'b0;
                end
            end
            default: begin
                nxt_state = PMSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff     <= PMSR_IDLE;
            bit_cnt_ff   <= 5'd0;
            cmd_ff       <= 8'h00;
            glob_snap_ff <= 8'h00;
            data_snap_ff <= 16'h0000;
            miso_ff      <= 1'b0;
            sclk_d_ff    <= 1'b0;
            csel_d_ff    <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            bit_cnt_ff   <= nxt_bit_cnt;
            cmd_ff       <= nxt_cmd;
            glob_snap_ff <= nxt_glob_snap;
            data_snap_ff <= nxt_data_snap;
            miso_ff      <= nxt_miso;
            sclk_d_ff    <= spi_sclk;
            csel_d_ff    <= spi_csel_n;
        end
    end

    assign spi_miso      = miso_ff;
    assign spi_miso_oe_n = spi_csel_n;

    // A slow supply ramp stays below threshold past the filter and is then flagged.
    always_comb begin
        nxt_uv_cnt = 13'd0;
        if (supply_uv_raw) begin
            nxt_uv_cnt = (uv_cnt_ff == UV_FILTER_CYC[12:0]) ? uv_cnt_ff : uv_cnt_ff + 13'd1;
        end
    end
    assign uv_filt = supply_uv_raw & (uv_cnt_ff == UV_FILTER_CYC[12:0]);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            uv_cnt_ff <= 13'd0;
        end else begin
            uv_cnt_ff <= nxt_uv_cnt;
        end
    end

    // Supply flags follow the condition unless lockout asks them to latch.
    always_comb begin
        s1_event = first_event & ~`PMSR_S1_SUPPLY_MASK;
        s1_event[`PMSR_S1_UV] = uv_filt;
        s1_event[`PMSR_S1_OV] = supply_ov_raw;
        s1_follow = lockout_enable_setting ? 16'h0000 : `PMSR_S1_SUPPLY_MASK;
    end

    pmsr_flag_bank #(.W(16)) u_first (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .event_in (s1_event),
        .follow   (s1_follow),
        .clear    (clr_first),
        .flags_ff (s1_q)
    );

    pmsr_flag_bank #(.W(16)) u_second (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .event_in (second_event),
        .follow   (`PMSR_S2_LIVE_MASK),
        .clear    (clr_second),
        .flags_ff (s2_q)
    );

    pmsr_flag_bank #(.W(16)) u_third (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .event_in (third_event),
        .follow   (`PMSR_S3_LIVE_MASK),
        .clear    (clr_third),
        .flags_ff (s3_q)
    );

    assign first_status_register  = s1_q;
    assign second_status_register = s2_q;
    assign third_status_register  = s3_q;

    // Global summary flags; in each, a new event beats a clear in the same cycle.
    always_comb begin
        nxt_comm     = comm_err_evt | (comm_ff & ~clr_third);
        nxt_not_cold = ~comm_err_evt & (not_cold_ff | clr_third);
        nxt_thermal_shutdown_second_level     = thermal_shutdown_second_level_event | (thermal_shutdown_second_level_ff & ~clr_third);
        // Supply faults never reach fail-safe; only watchdog, data-input and THERMAL_SHUTDOWN_SECOND_LEVEL do.
        nxt_fsafe    = failsafe_event | thermal_shutdown_second_level_event
                       | (fsafe_ff & ~(watchdog_trigger_ok | clr_third));
        nxt_global = 8'h00;
        nxt_global[`PMSR_G_COMM]        = nxt_comm;
        nxt_global[`PMSR_G_NOT_COLD]    = nxt_not_cold;
        nxt_global[`PMSR_G_THERMAL_SHUTDOWN_SECOND_LEVEL]        = nxt_thermal_shutdown_second_level;
        nxt_global[`PMSR_G_THERMAL_SHUTDOWN_FIRST_LEVEL]        = s3_q[`PMSR_S3_THERMAL_SHUTDOWN_FIRST_LEVEL];
        nxt_global[`PMSR_G_MAIN_FAIL]   = s3_q[`PMSR_S3_MAIN_FAIL];
        nxt_global[`PMSR_G_SUPPLY_FAIL] = s1_q[`PMSR_S1_UV] | s1_q[`PMSR_S1_OV];
        nxt_global[`PMSR_G_FAIL_SAFE]   = nxt_fsafe;
        // Cold start counts as an error because bit 5 is active low.
        nxt_global[`PMSR_G_ERROR] = nxt_comm | ~nxt_not_cold | nxt_thermal_shutdown_second_level
                                    | (|nxt_global[4:0])
                                    | (|(s1_q & `PMSR_S1_ERROR_MASK))
                                    | (|(s3_q & `PMSR_S3_ERROR_MASK));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            comm_ff          <= 1'b0;
            not_cold_ff      <= 1'b0;
            thermal_shutdown_second_level_ff          <= 1'b0;
            fsafe_ff         <= 1'b0;
            global_status_ff <= `PMSR_GLOBAL_RESET;
        end else begin
            comm_ff          <= nxt_comm;
            not_cold_ff      <= nxt_not_cold;
            thermal_shutdown_second_level_ff          <= nxt_thermal_shutdown_second_level;
            fsafe_ff         <= nxt_fsafe;
            global_status_ff <= nxt_global;
        end
    end

endmodule : pmsr_status_bank

// ---- rtl/pmsr_params.svh ----
// Functional notes
// - Global error bit 7 ORs global bits 0-6, first register 0-10, third register 2,3,15.
// - A frame with a wrong serial clock count sets communication error bit 6.
// - Global bit 5 is active low: 0 after chip reset or communication error.
// - Only the clear command on the third register returns bit 5 to 1.
// - Second-level thermal shutdown bit 4 clears only on third register read-and-clear.
// - Supply fail bit 1 is diagnosis only, never fail-safe, cleared by read-and-clear.
// - With lockout disabled, supply fail clears itself once supply is back in range.
// - Fail-safe bit 0 clears on a valid watchdog trigger or related register clear.
// - Supply undervoltage must persist 64 us before it is flagged.
// - Failures only in registers one to three give global value A0; second register flags reach no global bit here.
// - Data-input stuck fault gives A1, same as a watchdog failure.
// - Supply over/undervoltage in normal operation gives A2.
// - First register holds open-load, UV, regulator fail/short, OV, overcurrent flags.
// - Open-load and overcurrent flags latch until read-and-clear of the first register.
// - UV/OV flags follow the condition with lockout 0, latch with lockout 1.
`ifndef PMSR_PARAMS_SVH
`define PMSR_PARAMS_SVH

`define PMSR_CLK_MHZ         100
`define PMSR_UV_FILTER_US    64
`define PMSR_UV_FILTER_CYC   (`PMSR_UV_FILTER_US * `PMSR_CLK_MHZ)
`define PMSR_FRAME_BITS      5'd24
`define PMSR_CMD_BITS        5'd8

`define PMSR_ADDR_FIRST      6'h11
`define PMSR_ADDR_SECOND     6'h12
`define PMSR_ADDR_THIRD      6'h13
`define PMSR_OP_READ_CLEAR   2'h2

`define PMSR_GLOBAL_RESET    8'h80
`define PMSR_G_ERROR         7
`define PMSR_G_COMM          6
`define PMSR_G_NOT_COLD      5
`define PMSR_G_THERMAL_SHUTDOWN_SECOND_LEVEL          4
`define PMSR_G_THERMAL_SHUTDOWN_FIRST_LEVEL          3
`define PMSR_G_MAIN_FAIL     2
`define PMSR_G_SUPPLY_FAIL   1
`define PMSR_G_FAIL_SAFE     0

`define PMSR_S1_UV           10
`define PMSR_S1_OV           7
`define PMSR_S1_SUPPLY_MASK  16'h0480
`define PMSR_S1_ERROR_MASK   16'h07ff
`define PMSR_S3_ERROR_MASK   16'h800c
`define PMSR_S3_THERMAL_SHUTDOWN_FIRST_LEVEL         15
`define PMSR_S3_MAIN_FAIL    11
`define PMSR_S2_LIVE_MASK    16'he000
`define PMSR_S3_LIVE_MASK    16'h3003

`endif

// ---- rtl/pmsr_pkg.sv ----
package pmsr_pkg;

    typedef enum logic [2:0] {
        PMSR_IDLE = 3'b001,
        PMSR_CMD  = 3'b010,
        PMSR_DATA = 3'b100
    } pmsr_frame_e;

    typedef logic [15:0] pmsr_word_t;

endpackage : pmsr_pkg

// ---- rtl/pmsr_flag_bank.sv ----
`timescale 1ns/1ps
module pmsr_flag_bank #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Flag control
    input  wire logic [W-1:0] event_in,
    input  wire logic [W-1:0] follow,
    input  wire logic         clear,
    // Flag state
    output logic      [W-1:0] flags_ff
);

    logic [W-1:0] nxt_flags;

    // A set in the clear cycle survives, so no event is lost to a read.
    always_comb begin
        nxt_flags = (follow & event_in) | (~follow & ((flags_ff & ~{W{clear}}) | event_in));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

endmodule : pmsr_flag_bank

// ---- dv/pmsr_host.sv ----
`timescale 1ns/1ps
module pmsr_host (
    // Bench control
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [7:0]  cmd,
    input  wire logic [4:0]  nbits,
    input  wire logic [3:0]  half,
    output logic             busy = 1'b0,
    output logic [23:0]      rx = 24'h000000,
    // Serial lines
    output logic             spi_csel_n = 1'b1,
    output logic             spi_sclk = 1'b0,
    output logic             serial_data_input = 1'b0,
    input  wire logic        spi_miso
);
    // The serial clock stays low between frames, as a real host leaves it.
    always @(posedge clk_sys) begin
        if (go && !busy) begin
            busy = 1'b1;
            #1 spi_csel_n = 1'b0;
            for (int i = 0; i < nbits; i++) begin
                serial_data_input = ({cmd, 16'h0000} >> (23 - i)) & 1'b1;
                repeat (half) @(posedge clk_sys);
                #1 rx = {rx[22:0], spi_miso};
                spi_sclk = 1'b1;
                repeat (half) @(posedge clk_sys);
                #1 spi_sclk = 1'b0;
            end
            repeat (half) @(posedge clk_sys);
            #1 spi_csel_n = 1'b1;
            serial_data_input = ~serial_data_input;
            repeat (4) @(posedge clk_sys);
            #1 busy = 1'b0;
        end
    end
endmodule : pmsr_host

// ---- dv/pmsr_status_bank_props.sv ----
`timescale 1ns/1ps
module pmsr_status_bank_props #(
    parameter int UV_FILTER_CYC = 8
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Watched inputs
    input wire logic        spi_csel_n,
    input wire logic        supply_uv_raw,
    input wire logic        thermal_shutdown_second_level_event,
    input wire logic        failsafe_event,
    input wire logic        watchdog_trigger_ok,
    input wire logic        lockout_enable_setting,
    // Watched outputs
    input wire logic [15:0] first_status_register,
    input wire logic [7:0]  global_status_ff
);
    logic [15:0] uv_cnt_ff;
    logic [15:0] nxt_uv_cnt;
    always_comb begin
        nxt_uv_cnt = supply_uv_raw ? uv_cnt_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_sys) begin
        uv_cnt_ff <= rst ? 16'h0000 : nxt_uv_cnt;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_global_summary: assert property (|{global_status_ff[6], global_status_ff[4:0]} |-> ##[0:2] global_status_ff[7]) else $error("global error flag missing");
    a_first_summary: assert property (|first_status_register[10:0] |-> ##[0:2] global_status_ff[7]) else $error("first register not summarised");
    a_thermal_shutdown_second_level_frame_hold: assert property (!spi_csel_n && global_status_ff[4] |=> global_status_ff[4]) else $error("thermal bit dropped in frame");
    a_cold_frame_hold: assert property (!spi_csel_n && !global_status_ff[5] |=> !global_status_ff[5]) else $error("cold start left in frame");
    a_supply_latched: assert property (lockout_enable_setting && !spi_csel_n && first_status_register[7] |=> first_status_register[7]) else $error("latched overvoltage lost");
    a_failsafe_set: assert property (failsafe_event |-> ##[1:2] global_status_ff[0]) else $error("fail-safe not set");
    a_thermal_shutdown_second_level_set: assert property (thermal_shutdown_second_level_event |-> ##[1:2] (global_status_ff[4] && global_status_ff[0])) else $error("thermal shutdown not flagged");
    a_wd_clear: assert property (watchdog_trigger_ok && !failsafe_event && !thermal_shutdown_second_level_event |-> ##[1:2] !global_status_ff[0]) else $error("fail-safe not cleared");
    a_uv_filter: assert property ($rose(first_status_register[10]) |-> uv_cnt_ff >= UV_FILTER_CYC - 1) else $error("undervoltage flagged early");
endmodule : pmsr_status_bank_props
bind pmsr_status_bank pmsr_status_bank_props #(.UV_FILTER_CYC(UV_FILTER_CYC)) u_props (.*);

// ---- dv/pmsr_status_bank_tb.sv ----
`timescale 1ns/1ps
module pmsr_status_bank_tb;
    logic clk_sys = 1'b0, rst = 1'b1, go = 1'b0, busy, spi_csel_n, spi_sclk;
    logic serial_data_input, spi_miso, spi_miso_oe_n;
    logic supply_uv_raw = 1'b0, supply_ov_raw = 1'b0, thermal_shutdown_second_level_event = 1'b0;
    logic failsafe_event = 1'b0, watchdog_trigger_ok = 1'b0, lockout_enable_setting = 1'b0;
    logic [7:0]  cmd = 8'h00, global_status_ff;
    logic [4:0]  nbits = 5'd24;
    logic [3:0]  half = 4'h2;
    logic [23:0] rx;
    logic [15:0] first_event = 16'h0000, ev, first_status_register;
    logic [15:0] second_status_register, third_status_register;
    logic [15:0] second_event = 16'h0000, third_event = 16'h0000;
    logic [31:0] seed = 32'hfa5e1505;
    int fails = 0, compares = 0, cycles = 0;
    pmsr_status_bank #(.UV_FILTER_CYC(8)) uut (.*);
    pmsr_host host (.*);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] exp_glob(input logic [15:0] e);
        return (|(e & 16'h07ff)) ? 16'h00a0 : 16'h0020;
    endfunction : exp_glob
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic frame(input logic [7:0] c, input logic [4:0] n);
        cmd = c;
        nbits = n;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (int i = 0; i < 2000 && busy; i++) tick(1);
    endtask : frame
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(3);
    endtask : pulse
    task automatic end_sim();
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        tick(8);
        rst = 1'b0;
        tick(2);
        frame(8'h3f, 5'd24);
        chk({8'h00, rx[23:16]}, 16'h0080);
        chk(rx[15:0], 16'h0000);
        frame(8'h93, 5'd24);
        chk({8'h00, global_status_ff}, 16'h0020);
        half = 4'h5;
        frame(8'h13, 5'd16);
        chk({8'h00, global_status_ff}, 16'h00c0);
        frame(8'h93, 5'd24);
        chk({8'h00, global_status_ff}, 16'h0020);
        half = 4'h2;
        pulse(failsafe_event);
        chk({8'h00, global_status_ff}, 16'h00a1);
        pulse(watchdog_trigger_ok);
        chk({8'h00, global_status_ff}, 16'h0020);
        pulse(thermal_shutdown_second_level_event);
        frame(8'h91, 5'd24);
        chk({8'h00, global_status_ff}, 16'h00b1);
        frame(8'h93, 5'd24);
        chk({8'h00, rx[23:16]}, 16'h00b1);
        chk({8'h00, global_status_ff}, 16'h0020);
        supply_ov_raw = 1'b1;
        tick(4);
        chk({8'h00, global_status_ff}, 16'h00a2);
        supply_ov_raw = 1'b0;
        tick(4);
        chk({8'h00, global_status_ff}, 16'h0020);
        lockout_enable_setting = 1'b1;
        pulse(supply_ov_raw);
        chk({8'h00, global_status_ff}, 16'h00a2);
        frame(8'h91, 5'd24);
        chk({8'h00, global_status_ff}, 16'h0020);
        lockout_enable_setting = 1'b0;
        supply_uv_raw = 1'b1;
        tick(6);
        supply_uv_raw = 1'b0;
        tick(4);
        chk(first_status_register, 16'h0000);
        supply_uv_raw = 1'b1;
        tick(14);
        chk(first_status_register, 16'h0400);
        supply_uv_raw = 1'b0;
        tick(4);
        chk(first_status_register, 16'h0000);
        // Third register bit 2 reaches the error flag without a global bit of its own; bit 15 also sets global bit 3.
        third_event = 16'h0004;
        tick(1);
        third_event = 16'h0000;
        tick(3);
        chk(third_status_register, 16'h0004);
        chk({8'h00, global_status_ff}, 16'h00a0);
        third_event = 16'h8000;
        tick(1);
        third_event = 16'h0000;
        tick(3);
        chk({8'h00, global_status_ff}, 16'h00a8);
        frame(8'h93, 5'd24);
        chk(rx[15:0], 16'h8004);
        chk(third_status_register, 16'h0000);
        chk({8'h00, global_status_ff}, 16'h0020);
        second_event = 16'h0001;
        tick(1);
        second_event = 16'h0000;
        tick(3);
        frame(8'h92, 5'd24);
        chk(rx[15:0], 16'h0001);
        chk(second_status_register, 16'h0000);
        chk({15'h0000, spi_miso_oe_n}, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            // The first pass sets open-load flags only, which leave the error flag low.
            ev = (k == 0) ? 16'hf800 : seed[15:0] & 16'hfb7f;
            first_event = ev;
            tick(1);
            first_event = 16'h0000;
            tick(3);
            chk(first_status_register, ev);
            chk({8'h00, global_status_ff}, exp_glob(ev));
            half = 4'h2 + {2'b00, seed[17:16]};
            frame(8'h91, 5'd24);
            chk(rx[15:0], ev);
            chk(first_status_register, 16'h0000);
        end
        // A reset in mid-run must bring back the power-on summary.
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        chk({8'h00, global_status_ff}, 16'h0080);
        chk(first_status_register, 16'h0000);
        end_sim();
    end
endmodule : pmsr_status_bank_tb
